// [hw/sfd_top.v]
// supply fault detector configuration bank and two detector channels
`timescale 1ns/1ps
`include "sfd_map.vh"

// Functional notes
// - supply-4 overvoltage trip drops by 5-bit hysteresis while overvoltage asserted
// - high-voltage release level is threshold minus hysteresis while overvoltage
// - supply-4 range code 00 selects high range, 2.5 V to 6.0 V
// - supply-4 range code 01 selects mid range, 1.25 V to 3.00 V
// - supply-4 range codes 10 and 11 select ultralow range
module sfd_top #(
  parameter [6:0] DEV_ADDR = `SFD_DEV_ADDR
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire [7:0] sup4_code,
  input  wire [7:0] hv_code,
  output wire       sup4_ov_fault,
  output wire       sup4_uv_fault,
  output wire       sup4_fault,
  output wire       hv_ov_fault,
  output wire       hv_uv_fault,
  output wire       hv_fault,
  output reg        sup4_range_high,
  output reg        sup4_range_mid,
  output reg        sup4_range_ulow,
  output reg        hv_range_high
);
  // ========================================================================
  // register storage, channel 0 is supply 4, channel 1 the high-voltage one
  reg  [7:0]  ovth_r [0:1];
  reg  [4:0]  ovhy_r [0:1];
  reg  [7:0]  uvth_r [0:1];
  reg  [4:0]  s4_uvhy_r;
  reg  [4:0]  cfg_r  [0:1];
  reg  [1:0]  s4_sel_r;
  reg         hv_sel_r;
  reg  [1:0]  ov_q_r;
  reg  [1:0]  uv_q_r;
  reg  [1:0]  flt_r;
  reg  [7:0]  rd_data;

  wire [7:0]  ptr;
  wire        wr_en;
  wire [7:0]  wr_data;
  wire [7:0]  code_w [0:1];
  wire [4:0]  uvhy_w [0:1];

  assign code_w[0] = sup4_code;
  assign code_w[1] = hv_code;
  assign uvhy_w[0] = s4_uvhy_r;
  // the high-voltage channel has no undervoltage hysteresis register
  assign uvhy_w[1] = 5'h00;

  sfd_bus_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_bus (
    .clk     (clk),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .ptr_r   (ptr),
    .rd_data (rd_data),
    .wr_en   (wr_en),
    .wr_data (wr_data)
  );

  // ========================================================================
  // register writes; unused bits are not stored and read back as zero
  always @(posedge clk) begin
    if (!rst_n) begin
      ovth_r[0] <= `SFD_RST_TH;
      ovth_r[1] <= `SFD_RST_TH;
      ovhy_r[0] <= `SFD_RST_HY;
      ovhy_r[1] <= `SFD_RST_HY;
      uvth_r[0] <= `SFD_RST_TH;
      uvth_r[1] <= `SFD_RST_TH;
      s4_uvhy_r <= `SFD_RST_HY;
      cfg_r[0]  <= `SFD_RST_CFG;
      cfg_r[1]  <= `SFD_RST_CFG;
      s4_sel_r  <= `SFD_RST_SEL;
      hv_sel_r  <= 1'b0;
    end else if (wr_en) begin
      if (ptr == `SFD_OFF_S4_OVTH) begin
        ovth_r[0] <= wr_data;
      end else if (ptr == `SFD_OFF_S4_OVHY) begin
        ovhy_r[0] <= wr_data[`SFD_HY_MSB:0];
      end else if (ptr == `SFD_OFF_S4_UVTH) begin
        uvth_r[0] <= wr_data;
      end else if (ptr == `SFD_OFF_S4_UVHY) begin
        s4_uvhy_r <= wr_data[`SFD_HY_MSB:0];
      end else if (ptr == `SFD_OFF_S4_CFG) begin
        cfg_r[0] <= wr_data[`SFD_GF_MSB:0];
      end else if (ptr == `SFD_OFF_S4_SEL) begin
        s4_sel_r <= wr_data[`SFD_SEL4_MSB:0];
      end else if (ptr == `SFD_OFF_HV_OVTH) begin
        ovth_r[1] <= wr_data;
      end else if (ptr == `SFD_OFF_HV_OVHY) begin
        ovhy_r[1] <= wr_data[`SFD_HY_MSB:0];
      end else if (ptr == `SFD_OFF_HV_UVTH) begin
        uvth_r[1] <= wr_data;
      end else if (ptr == `SFD_OFF_HV_CFG) begin
        cfg_r[1] <= wr_data[`SFD_GF_MSB:0];
      end else if (ptr == `SFD_OFF_HV_SEL) begin
        hv_sel_r <= wr_data[`SFD_SELH_BIT];
      end
    end
  end

  // ========================================================================
  // read mux; unmapped offsets read zero
  always @* begin
    rd_data = 8'h00;
    if (ptr == `SFD_OFF_S4_OVTH) begin
      rd_data = ovth_r[0];
    end else if (ptr == `SFD_OFF_S4_OVHY) begin
      rd_data = {3'h0, ovhy_r[0]};
    end else if (ptr == `SFD_OFF_S4_UVTH) begin
      rd_data = uvth_r[0];
    end else if (ptr == `SFD_OFF_S4_UVHY) begin
      rd_data = {3'h0, s4_uvhy_r};
    end else if (ptr == `SFD_OFF_S4_CFG) begin
      rd_data = {3'h0, cfg_r[0]};
    end else if (ptr == `SFD_OFF_S4_SEL) begin
      rd_data = {6'h00, s4_sel_r};
    end else if (ptr == `SFD_OFF_HV_OVTH) begin
      rd_data = ovth_r[1];
    end else if (ptr == `SFD_OFF_HV_OVHY) begin
      rd_data = {3'h0, ovhy_r[1]};
    end else if (ptr == `SFD_OFF_HV_UVTH) begin
      rd_data = uvth_r[1];
    end else if (ptr == `SFD_OFF_HV_CFG) begin
      rd_data = {3'h0, cfg_r[1]};
    end else if (ptr == `SFD_OFF_HV_SEL) begin
      rd_data = {7'h00, hv_sel_r};
    end else if (ptr == `SFD_OFF_STATUS) begin
      rd_data = {2'h0, flt_r[1], flt_r[0], uv_q_r[1], ov_q_r[1],
                 uv_q_r[0], ov_q_r[0]};
    end
  end

  // ========================================================================
  // range selection decoded into registered attenuator controls
  always @(posedge clk) begin
    if (!rst_n) begin
      sup4_range_high <= 1'b1;
      sup4_range_mid  <= 1'b0;
      sup4_range_ulow <= 1'b0;
      hv_range_high   <= 1'b0;
    end else begin
      sup4_range_high <= (s4_sel_r == `SFD_SEL_HIGH);
      sup4_range_mid  <= (s4_sel_r == `SFD_SEL_MID);
      sup4_range_ulow <= s4_sel_r[1];
      hv_range_high   <= hv_sel_r;
    end
  end

  // ========================================================================
  // glitch filter delay in cycles; 100 us is 4000 cycles, fits 12 bits
  function [11:0] gf_cycles;
    input [2:0] gf;
    reg   [31:0] t;
    begin
      case (gf)
        3'h0:    t = `SFD_GF0_US * `SFD_CLK_MHZ;
        3'h1:    t = `SFD_GF1_US * `SFD_CLK_MHZ;
        3'h2:    t = `SFD_GF2_US * `SFD_CLK_MHZ;
        3'h3:    t = `SFD_GF3_US * `SFD_CLK_MHZ;
        3'h4:    t = `SFD_GF4_US * `SFD_CLK_MHZ;
        3'h5:    t = `SFD_GF5_US * `SFD_CLK_MHZ;
        3'h6:    t = `SFD_GF6_US * `SFD_CLK_MHZ;
        default: t = `SFD_GF7_US * `SFD_CLK_MHZ;
      endcase
      gf_cycles = t[11:0];
    end
  endfunction

  // ========================================================================
  // detector channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg  [11:0] ov_cnt_r;
      reg  [11:0] uv_cnt_r;
      wire [8:0]  ov_dn  = {1'b0, ovth_r[ch]} - {4'h0, ovhy_r[ch]};
      wire [8:0]  uv_up  = {1'b0, uvth_r[ch]} + {4'h0, uvhy_w[ch]};
      // hysteresis clamps at the code range ends rather than wrapping
      wire [7:0]  ov_lvl = ov_q_r[ch] ? (ov_dn[8] ? 8'h00 : ov_dn[7:0])
                                      : ovth_r[ch];
      wire [7:0]  uv_lvl = uv_q_r[ch] ? (uv_up[8] ? 8'hFF : uv_up[7:0])
                                      : uvth_r[ch];
      wire        ov_raw = code_w[ch] > ov_lvl;
      wire        uv_raw = code_w[ch] < uv_lvl;
      wire [1:0]  rs     = cfg_r[ch][`SFD_RS_MSB:`SFD_RS_LSB];
      wire [11:0] dly    = gf_cycles(cfg_r[ch][`SFD_GF_MSB:`SFD_GF_LSB]);
      wire        ov_en  = (rs == `SFD_RS_OV) | (rs == `SFD_RS_UV_OV);
      wire        uv_en  = (rs == `SFD_RS_UV) | (rs == `SFD_RS_UV_OV);

      // a change must persist for the full delay before it is taken
      always @(posedge clk) begin
        if (!rst_n) begin
          ov_q_r[ch] <= 1'b0;
          uv_q_r[ch] <= 1'b0;
          flt_r[ch]  <= 1'b0;
          ov_cnt_r   <= 12'h000;
          uv_cnt_r   <= 12'h000;
        end else begin
          if (ov_raw == ov_q_r[ch]) begin
            ov_cnt_r <= 12'h000;
          end else if (ov_cnt_r >= dly) begin
            ov_q_r[ch] <= ov_raw;
            ov_cnt_r   <= 12'h000;
          end else begin
            ov_cnt_r <= ov_cnt_r + 12'h001;
          end
          if (uv_raw == uv_q_r[ch]) begin
            uv_cnt_r <= 12'h000;
          end else if (uv_cnt_r >= dly) begin
            uv_q_r[ch] <= uv_raw;
            uv_cnt_r   <= 12'h000;
          end else begin
            uv_cnt_r <= uv_cnt_r + 12'h001;
          end
          flt_r[ch] <= (ov_en & ov_q_r[ch]) | (uv_en & uv_q_r[ch]);
        end
      end
    end
  endgenerate

  assign sup4_ov_fault = ov_q_r[0];
  assign sup4_uv_fault = uv_q_r[0];
  assign sup4_fault    = flt_r[0];
  assign hv_ov_fault   = ov_q_r[1];
  assign hv_uv_fault   = uv_q_r[1];
  assign hv_fault      = flt_r[1];
endmodule // sfd_top

// [hw/sfd_map.vh]
// register map, field positions, reset values and timing for the detectors
`ifndef SFD_MAP_VH
`define SFD_MAP_VH

// ==========================================================================
// register offsets
`define SFD_OFF_S4_OVTH    8'h18
`define SFD_OFF_S4_OVHY    8'h19
`define SFD_OFF_S4_UVTH    8'h1A
`define SFD_OFF_S4_UVHY    8'h1B
`define SFD_OFF_S4_CFG     8'h1C
`define SFD_OFF_S4_SEL     8'h1D
`define SFD_OFF_HV_OVTH    8'h20
`define SFD_OFF_HV_OVHY    8'h21
`define SFD_OFF_HV_UVTH    8'h22
`define SFD_OFF_HV_CFG     8'h24
`define SFD_OFF_HV_SEL     8'h25
`define SFD_OFF_STATUS     8'h26

// ==========================================================================
// field positions
`define SFD_HY_MSB         4
`define SFD_GF_MSB         4
`define SFD_GF_LSB         2
`define SFD_RS_MSB         1
`define SFD_RS_LSB         0
`define SFD_SEL4_MSB       1
`define SFD_SELH_BIT       0

// ==========================================================================
// reset values
`define SFD_RST_TH         8'h00
`define SFD_RST_HY         5'h00
`define SFD_RST_CFG        5'h00
`define SFD_RST_SEL        2'h0

// ==========================================================================
// fault type and range codes
`define SFD_RS_OV          2'h0
`define SFD_RS_UV_OV       2'h1
`define SFD_RS_UV          2'h2
`define SFD_SEL_HIGH       2'h0
`define SFD_SEL_MID        2'h1

// ==========================================================================
// timing
`define SFD_CLK_MHZ        40
`define SFD_GF0_US         0
`define SFD_GF1_US         5
`define SFD_GF2_US         10
`define SFD_GF3_US         20
`define SFD_GF4_US         30
`define SFD_GF5_US         50
`define SFD_GF6_US         75
`define SFD_GF7_US         100

// arbitrary bus address, no meaning
`define SFD_DEV_ADDR       7'h2A

`endif

// [hw/sfd_bus_slave.v]
// two-wire management bus slave: pointer write, byte writes and reads
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_bus_slave #(
  parameter [6:0] DEV_ADDR = `SFD_DEV_ADDR
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg  [7:0] ptr_r,
  input  wire [7:0] rd_data,
  output reg        wr_en,
  output reg  [7:0] wr_data
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;

  // ========================================================================
  // pin synchronisers; only the second stage and its one-cycle delayed copy are looked at
  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       scl_d_r;
  reg       sda_s1_r;
  reg       sda_s2_r;
  reg       sda_d_r;
  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [1:0] byte_r;
  reg       rw_r;

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire start    = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop     = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  // ========================================================================
  // byte engine; open drain, so the data line is only ever pulled low
  always @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= ST_IDLE;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      byte_r  <= 2'h0;
      rw_r    <= 1'b0;
      ptr_r   <= 8'h00;
      wr_en   <= 1'b0;
      wr_data <= 8'h00;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (start) begin
        st_r   <= ST_RX;
        bit_r  <= 4'h0;
        byte_r <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_r   <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          ST_RX: begin
            if (scl_rise && bit_r != 4'h8) begin
              sh_r  <= {sh_r[6:0], sda_s2_r};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              if (byte_r == 2'h0) begin
                if (sh_r[7:1] == DEV_ADDR) begin
                  rw_r   <= sh_r[0];
                  sda_oe <= 1'b1;
                  st_r   <= ST_ACK;
                end else begin
                  st_r <= ST_IDLE;
                end
              end else begin
                if (byte_r == 2'h1) begin
                  ptr_r <= sh_r;
                end else begin
                  wr_en   <= 1'b1;
                  wr_data <= sh_r;
                end
                sda_oe <= 1'b1;
                st_r   <= ST_ACK;
              end
              if (byte_r != 2'h2) begin
                byte_r <= byte_r + 2'h1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (rw_r) begin
                sh_r   <= {rd_data[6:0], 1'b0};
                sda_oe <= ~rd_data[7];
                st_r   <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                st_r   <= ST_RX;
              end
            end
            if (wr_en) begin
              ptr_r <= ptr_r + 8'h01;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe <= 1'b0;
                st_r   <= ST_RACK;
              end else begin
                sda_oe <= ~sh_r[7];
                sh_r   <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              // a master nack ends the read; wait for stop
              if (sda_s2_r) begin
                st_r <= ST_IDLE;
              end else begin
                ptr_r <= ptr_r + 8'h01;
                st_r  <= ST_ACK;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sfd_bus_slave

// [sim/sfd_top_checker.sv]
// port checker for the supply fault detector bank
`timescale 1ns/1ps
// ==========================================================================
// checker
module sfd_top_chk (
  input wire       clk,
  input wire       rst_n,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [7:0] sup4_code,
  input wire [7:0] hv_code,
  input wire       sup4_ov_fault,
  input wire       hv_ov_fault,
  input wire       sup4_fault,
  input wire       hv_fault,
  input wire       sup4_range_high,
  input wire       sup4_range_mid,
  input wire       sup4_range_ulow,
  input wire       hv_range_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  range_onehot_a: assert property (
    $onehot({sup4_range_high, sup4_range_mid, sup4_range_ulow}))
    else $error("range outputs not one-hot");
  // the level never goes below zero, so a zero code cannot trip
  // the flag is taken on the edge where the raw compare last held
  sup4_ov_rise_a: assert property (
    $rose(sup4_ov_fault) |-> $past(sup4_code) != 8'h00)
    else $error("supply-4 overvoltage rose on zero code");
  hv_ov_rise_a: assert property (
    $rose(hv_ov_fault) |-> $past(hv_code) != 8'h00)
    else $error("high-voltage overvoltage rose on zero code");
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> !sup4_ov_fault && !hv_ov_fault && !sup4_fault &&
      !hv_fault && !sda_oe)
    else $error("faults or bus drive active after reset");
  reset_range_a: assert property (disable iff (1'b0)
    !rst_n |=> sup4_range_high && !hv_range_high)
    else $error("range outputs wrong after reset");
  open_drain_a: assert property (
    sda_oe |-> !sda_out)
    else $error("data line driven high");

  cover property ($rose(sup4_ov_fault));
  cover property ($fell(hv_ov_fault));
  cover property ($rose(sup4_range_ulow));
endmodule // sfd_top_chk

bind sfd_top sfd_top_chk chk (.clk, .rst_n, .sda_out, .sda_oe, .sup4_code,
  .hv_code, .sup4_ov_fault, .hv_ov_fault, .sup4_fault, .hv_fault,
  .sup4_range_high, .sup4_range_mid, .sup4_range_ulow, .hv_range_high);

// [sim/sfd_top_test.sv]
// self-checking bench for the supply fault detector bank
`timescale 1ns/1ps
`include "sfd_map.vh"
// ==========================================================================
// bench
module sfd_top_test;
  reg         clk, rst_n, scl_in, sda_m;
  reg  [7:0]  sup4_code, hv_code, obs_v, rb;
  reg  [31:0] seed;
  wire        sda_in, sda_out, sda_oe, sup4_ov_fault, sup4_uv_fault;
  wire        sup4_fault, hv_ov_fault, hv_uv_fault, hv_fault;
  wire        sup4_range_high, sup4_range_mid, sup4_range_ulow;
  wire        hv_range_high;
  int         num_errors, checks, i, d;
  logic [7:0] q[$];
  logic [7:0] oq[$];
  event       got;
  logic [7:0] offs [12] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
                            8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h1E};
  logic [7:0] msk [12]  = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03,
                            8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h01, 8'h00};
  logic [7:0] s4v [3]   = '{8'h81, 8'h7C, 8'h7B};
  logic [7:0] hvv [3]   = '{8'h41, 8'h22, 8'h21};
  int         us [8]    = '{0, 5, 10, 20, 30, 50, 75, 100};

  // open drain with pull-up
  assign sda_in = sda_m & ~sda_oe;

  sfd_top dut (.clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .sup4_code, .hv_code, .sup4_ov_fault, .sup4_uv_fault, .sup4_fault,
    .hv_ov_fault, .hv_uv_fault, .hv_fault, .sup4_range_high,
    .sup4_range_mid, .sup4_range_ulow, .hv_range_high);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ========================================================================
  // helpers
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // eight cycles per phase keeps clear of the pin synchroniser delay
  task half;
    repeat (8) @(posedge clk);
  endtask
  task bo(input b);
    half; sda_m <= b; half; scl_in <= 1'b1; half; scl_in <= 1'b0;
  endtask
  task bi(output b);
    half; sda_m <= 1'b1; half; scl_in <= 1'b1; half;
    @(negedge clk) b = sda_in;
    @(posedge clk) scl_in <= 1'b0;
  endtask
  task st;
    half; sda_m <= 1'b1; half; scl_in <= 1'b1;
    half; sda_m <= 1'b0; half; scl_in <= 1'b0;
  endtask
  task sp;
    half; sda_m <= 1'b0; half; scl_in <= 1'b1; half; sda_m <= 1'b1; half;
  endtask
  task by(input [7:0] v);
    reg a;
    for (int k = 7; k >= 0; k--) bo(v[k]);
    bi(a);
  endtask
  task note(input [7:0] v, input [7:0] e);
    q.push_back(e);
    oq.push_back(v);
    obs_v = v;
    ->got;
  endtask
  task wr(input [7:0] a, input [7:0] v);
    st; by({`SFD_DEV_ADDR, 1'b0}); by(a); by(v); sp;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    reg [7:0] v;
    reg       b;
    st; by({`SFD_DEV_ADDR, 1'b0}); by(a); st; by({`SFD_DEV_ADDR, 1'b1});
    for (int k = 7; k >= 0; k--) begin
      bi(b);
      v[k] = b;
    end
    bo(1'b1); sp;
    note(v, e);
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ========================================================================
  // result watcher: oldest note against each observed result
  initial forever begin
    @(got);
    // two notes in one time step wake this only once, so drain all
    while (oq.size() > 0) begin
      if (q.size() == 0) begin
        num_errors++;
        $display("CHECK FAILED %0t result without expectation", $time);
        void'(oq.pop_front());
      end else
        cmp(oq.pop_front(), q.pop_front());
    end
  end

  // a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED %0t run too long", $time);
    close_out;
  end

  // ========================================================================
  // stimulus
  initial begin
    rst_n = 1'b0; scl_in = 1'b1; sda_m = 1'b1; sup4_code = 8'h00;
    hv_code = 8'h00; seed = 66349; num_errors = 0; checks = 0;
    wt(10);
    @(posedge clk) rst_n <= 1'b1;
    wt(4);
    // reset values, random write and masked readback, unmapped place
    for (i = 0; i < 12; i++) begin
      rd(offs[i], 8'h00);
      seed = lfsr(seed);
      rb = seed[7:0];
      wr(offs[i], rb);
      rd(offs[i], rb & msk[i]);
    end
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      wr(8'h1D, i[7:0]);
      wr(8'h25, i[7:0]);
      wt(5);
      note({4'h0, hv_range_high, sup4_range_high, sup4_range_mid,
        sup4_range_ulow}, {4'h0, i[0], i == 0, i == 1, i > 1});
    end
    $display("range test done");
    // undervoltage off, no filter, overvoltage-only type
    wr(8'h1A, 8'h00); wr(8'h22, 8'h00); wr(8'h1C, 8'h00); wr(8'h24, 8'h00);
    wr(8'h18, 8'h80); wr(8'h19, 8'h05); wr(8'h20, 8'h40); wr(8'h21, 8'h1F);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      sup4_code <= s4v[i];
      hv_code   <= hvv[i];
      wt(8);
      note({6'h0, sup4_ov_fault, sup4_fault}, {6'h0, {2{i < 2}}});
      note({6'h0, hv_ov_fault, hv_fault}, {6'h0, {2{i < 2}}});
    end
    $display("hysteresis test done");
    for (i = 0; i < 8; i++) begin
      wr(8'h1C, {3'h0, i[2:0], 2'h0});
      d = us[i] * `SFD_CLK_MHZ;
      @(posedge clk) sup4_code <= 8'h81;
      if (d > 0) begin
        wt(d - 5);
        note({7'h0, sup4_ov_fault}, 8'h00);
        wt(15);
      end else
        wt(10);
      note({7'h0, sup4_ov_fault}, 8'h01);
      @(posedge clk) sup4_code <= 8'h00;
      wt(d + 10);
    end
    $display("glitch filter test done");
    close_out;
  end
endmodule // sfd_top_test
